/* rtl/cst_defines.vh */
// constants for the clock synth, serial out and tuning register bank
`ifndef CST_DEFINES_VH
`define CST_DEFINES_VH

// register offsets
`define CST_ADDR_FBD_HI     6'h12
`define CST_ADDR_FBD_LO     6'h13
`define CST_ADDR_PUMP       6'h14
`define CST_ADDR_FLT_HI     6'h15
`define CST_ADDR_FLT_LO     6'h16
`define CST_ADDR_SOC_A      6'h18
`define CST_ADDR_SOC_B      6'h19
`define CST_ADDR_RATE       6'h1a
`define CST_ADDR_TUNE       6'h1c
`define CST_ADDR_COARSE     6'h1d
`define CST_ADDR_FINE       6'h1e
`define CST_ADDR_RCCAP      6'h1f
`define CST_ADDR_RBEN       6'h3a
`define CST_ADDR_FLOAT      6'h3b
`define CST_ADDR_REV        6'h3f

// reset values
`define CST_RST_FBD_HI      5'h00
`define CST_RST_FBD_LO      8'h3c
`define CST_RST_PUMP        7'h03
`define CST_RST_FLT_HI      6'h00
`define CST_RST_FLT_LO      8'h04
`define CST_RST_SOC_A       8'h12
`define CST_RST_SOC_B       8'h07
`define CST_RST_RATE        4'h1

// field positions
`define CST_PUMP_FAST_BIT   6
`define CST_PUMP_POL_BIT    5
`define CST_PUMP_CUR_HI     4
`define CST_PUMP_CUR_LO     2
`define CST_PUMP_MODE_HI    1
`define CST_PUMP_MODE_LO    0
`define CST_TANK_TUNING_TRIGGER_BIT     1
`define CST_RESONATOR_RC_TUNING_TRIGGER_BIT     0
`define CST_RBEN_BIT        3
`define CST_FLOAT_BIT       3
`define CST_SOCB_4WIRE_BIT  7

// pump mode codes
`define CST_MODE_OFF        2'h0
`define CST_MODE_UP         2'h1
`define CST_MODE_DOWN       2'h2
`define CST_MODE_NORMAL     2'h3

// soft reset code and revision value (revision value is arbitrary)
`define CST_SOFT_RST_CODE   8'h99
`define CST_REVISION        8'h5a

// tuning duration in clock cycles: 2000 ns at the 40 ns clock, sized for the counter
`define CST_TUNE_CYCLES     16'h0032

`endif

/* rtl/cst_spi_port.v */
// serial configuration port: header decode, write bytes with auto-increment, read shift-out
`timescale 1ns/100ps
`include "cst_defines.vh"

module cst_spi_port
(
  // clock and control
  input  wire       clk_in,
  input  wire       rst_in,
  input  wire       ce_in,
  // port pins, already synchronous
  input  wire       sck_in,
  input  wire       sel_n_in,
  input  wire       sdi_in,
  // read side
  input  wire       rd_ok_in,
  input  wire [7:0] rd_data_in,
  // register side
  output reg        wr_stb_out,
  output reg  [5:0] addr_out,
  output reg  [7:0] wdata_out,
  output reg        sdo_out,
  output reg        sdo_oe_n_out
);

  reg       sck_prev_reg;
  reg [2:0] bit_cnt_reg;
  reg       hdr_done_reg;
  reg       is_rd_reg;
  reg       ld_pend_reg;
  reg       rd_run_reg;
  reg [7:0] in_sh_reg;
  reg [7:0] out_sh_reg;

  wire sck_rise = sck_in & ~sck_prev_reg;
  wire sck_fall = ~sck_in & sck_prev_reg;

  // frame engine; a partial byte at deselect is simply dropped
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      sck_prev_reg <= 1'b0;
      bit_cnt_reg  <= 3'h0;
      hdr_done_reg <= 1'b0;
      is_rd_reg    <= 1'b0;
      ld_pend_reg  <= 1'b0;
      rd_run_reg   <= 1'b0;
      in_sh_reg    <= 8'h00;
      out_sh_reg   <= 8'h00;
      wr_stb_out   <= 1'b0;
      addr_out     <= 6'h00;
      wdata_out    <= 8'h00;
      sdo_out      <= 1'b0;
      sdo_oe_n_out <= 1'b1;
    end
    else if (ce_in)
    begin
      sck_prev_reg <= sck_in;
      wr_stb_out   <= 1'b0;
      if (wr_stb_out)
        addr_out <= addr_out + 6'h01; // auto-increment for the next byte
      if (sel_n_in)
      begin
        bit_cnt_reg  <= 3'h0;
        hdr_done_reg <= 1'b0;
        is_rd_reg    <= 1'b0;
        ld_pend_reg  <= 1'b0;
        rd_run_reg   <= 1'b0;
        sdo_oe_n_out <= 1'b1; // release the data line
      end
      else
      begin
        if (sck_rise)
        begin
          in_sh_reg   <= {in_sh_reg[6:0], sdi_in};
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == 3'h7)
          begin
            if (!hdr_done_reg)
            begin
              hdr_done_reg <= 1'b1;
              is_rd_reg    <= in_sh_reg[6];
              addr_out     <= in_sh_reg[5:0];
              ld_pend_reg  <= in_sh_reg[6] & rd_ok_in; // reads gated by mode
            end
            else if (!is_rd_reg)
            begin
              wdata_out  <= {in_sh_reg[6:0], sdi_in};
              wr_stb_out <= 1'b1;
            end
          end
        end
        // read data is fetched one cycle after the address settles
        if (ld_pend_reg)
        begin
          ld_pend_reg <= 1'b0;
          out_sh_reg  <= rd_data_in;
          rd_run_reg  <= 1'b1;
        end
        else if (rd_run_reg && sck_fall)
        begin
          sdo_out      <= out_sh_reg[7];
          out_sh_reg   <= {out_sh_reg[6:0], 1'b0};
          sdo_oe_n_out <= 1'b0;
        end
      end
    end
  end

endmodule // cst_spi_port

/* rtl/cst_tune_engine.v */
// resonator tuning sequencer, one timed slot per section
`timescale 1ns/100ps
`include "cst_defines.vh"

module cst_tune_engine
#(
  parameter         NUM_SECT    = 2,
  parameter [15:0]  TUNE_CYCLES = `CST_TUNE_CYCLES
)
(
  // clock and control
  input  wire                clk_in,
  input  wire                rst_in,
  input  wire                ce_in,
  // start and status per section
  input  wire [NUM_SECT-1:0] start_in,
  output reg  [NUM_SECT-1:0] busy_out,
  output reg  [NUM_SECT-1:0] done_out
);

  genvar g;
  generate
    for (g = 0; g < NUM_SECT; g = g + 1)
    begin : sect
      reg [15:0] cnt_reg;
      // each section counts its own tuning interval
      always @(posedge clk_in)
      begin
        if (rst_in)
        begin
          cnt_reg     <= 16'h0000;
          busy_out[g] <= 1'b0;
          done_out[g] <= 1'b0;
        end
        else if (ce_in)
        begin
          done_out[g] <= 1'b0;
          if (!busy_out[g])
          begin
            if (start_in[g])
            begin
              busy_out[g] <= 1'b1;
              cnt_reg     <= TUNE_CYCLES - 16'h0001;
            end
          end
          else if (cnt_reg == 16'h0000)
          begin
            busy_out[g] <= 1'b0;
            done_out[g] <= 1'b1;
          end
          else
            cnt_reg <= cnt_reg - 16'h0001;
        end
      end
    end
  endgenerate

endmodule // cst_tune_engine

/* rtl/cst_regs_top.v */
// clock synth, serial output and tuning configuration register bank
`timescale 1ns/100ps
`include "cst_defines.vh"

module cst_regs_top
#(
  parameter [7:0]  REVISION_ID = `CST_REVISION,
  parameter [15:0] TUNE_CYCLES = `CST_TUNE_CYCLES
)
(
  // clock, reset, enable
  input  wire        MCLK_IN,
  input  wire        RST_IN,
  input  wire        CE_IN,
  // configuration port pins
  input  wire        SPORT_CLK_IN,
  input  wire        SPORT_SEL_N_IN,
  input  wire        SPORT_DATA_IN,
  output wire        SPORT_DATA_OUT,
  output wire        SPORT_DATA_OE_N_OUT,
  // secondary serial output pin
  output reg         SECONDARY_SERIAL_OUTPUT_OUT,
  output reg         SECONDARY_SERIAL_OUTPUT_OE_N_OUT,
  // clock synthesizer settings
  output reg  [12:0] CLOCK_FEEDBACK_DIVISOR_OUT,
  output reg         CLOCK_FAST_LOCK_ENABLE_OUT,
  output reg         CLOCK_PUMP_POLARITY_OUT,
  output reg  [3:0]  CLOCK_PUMP_STEPS_OUT,
  output reg         CLOCK_PUMP_UP_OUT,
  output reg         CLOCK_PUMP_DOWN_OUT,
  output reg         CLOCK_PUMP_NORMAL_OUT,
  output reg  [13:0] CLOCK_FAST_LOCK_TIME_OUT,
  // serial output settings
  output reg  [7:0]  SERIAL_OUT_CONTROL_A_OUT,
  output reg  [7:0]  SERIAL_OUT_CONTROL_B_OUT,
  output reg         SERIAL_OUTPUT_CLOCK_OUT,
  // resonator tuning
  output reg         TANK_TUNING_BUSY_OUT,
  output reg         RC_TUNING_BUSY_OUT,
  output reg  [2:0]  TANK_COARSE_CAP_OUT,
  output reg  [5:0]  TANK_FINE_CAP_OUT,
  output reg  [7:0]  RC_RESONATOR_CAP_OUT,
  // port mode status
  output reg         READBACK_ENABLE_OUT,
  output reg         FOUR_WIRE_MODE_OUT
);

  // register storage
  reg [4:0]  fbd_hi_reg;
  reg [12:0] fbd_reg;
  reg [6:0]  pump_reg;
  reg [5:0]  flt_hi_reg;
  reg [13:0] flt_reg;
  reg [7:0]  soc_a_reg;
  reg [7:0]  soc_b_reg;
  reg [3:0]  rate_reg;
  reg [1:0]  tune_reg;
  reg [1:0]  tune_next;
  reg [2:0]  coarse_reg;
  reg [5:0]  fine_reg;
  reg [7:0]  rccap_reg;
  reg        rben_reg;
  reg        float_reg;
  reg        soft_rst_reg;
  reg [3:0]  div_cnt_reg;
  reg [7:0]  rd_mux;

  // port side wires
  wire       wr_stb;
  wire [5:0] addr;
  wire [7:0] wdata;
  wire       sdo;
  wire [1:0] tune_busy;
  wire [1:0] tune_done;
  wire       bank_rst;
  wire       four_wire;
  wire       rd_ok;
  wire [1:0] tune_start;

  // software reset acts as a full power-on reset one cycle later
  assign bank_rst = RST_IN | soft_rst_reg;

  // four-wire needs control B bit 7 and the 0x3a read-back bit (bit 3) clear
  assign four_wire = soc_b_reg[`CST_SOCB_4WIRE_BIT] & ~rben_reg;

  // three-wire reads only with read-back enabled
  assign rd_ok = rben_reg | four_wire;

  // start pulses: a written one launches an idle section
  assign tune_start[1] = wr_stb & (addr == `CST_ADDR_TUNE) &
                         wdata[`CST_TANK_TUNING_TRIGGER_BIT] & ~tune_busy[1];
  assign tune_start[0] = wr_stb & (addr == `CST_ADDR_TUNE) &
                         wdata[`CST_RESONATOR_RC_TUNING_TRIGGER_BIT] & ~tune_busy[0];

  // serial configuration port
  cst_spi_port u_port
  (
    .clk_in       (MCLK_IN),
    .rst_in       (bank_rst),
    .ce_in        (CE_IN),
    .sck_in       (SPORT_CLK_IN),
    .sel_n_in     (SPORT_SEL_N_IN),
    .sdi_in       (SPORT_DATA_IN),
    .rd_ok_in     (rd_ok),
    .rd_data_in   (rd_mux),
    .wr_stb_out   (wr_stb),
    .addr_out     (addr),
    .wdata_out    (wdata),
    .sdo_out      (sdo),
    .sdo_oe_n_out (SPORT_DATA_OE_N_OUT)
  );

  assign SPORT_DATA_OUT = sdo;

  // tuning sequencer, index 1 is the tank, index 0 the rc section
  cst_tune_engine
  #(
    .NUM_SECT    (2),
    .TUNE_CYCLES (TUNE_CYCLES)
  )
  u_tune
  (
    .clk_in   (MCLK_IN),
    .rst_in   (bank_rst),
    .ce_in    (CE_IN),
    .start_in (tune_start),
    .busy_out (tune_busy),
    .done_out (tune_done)
  );

  // read mux; unlisted addresses and test registers read zero
  always @*
  begin
    rd_mux = 8'h00;
    if (addr == `CST_ADDR_FBD_HI)
      rd_mux = {3'h0, fbd_hi_reg};
    else if (addr == `CST_ADDR_FBD_LO)
      rd_mux = fbd_reg[7:0];
    else if (addr == `CST_ADDR_PUMP)
      rd_mux = {1'b0, pump_reg};
    else if (addr == `CST_ADDR_FLT_HI)
      rd_mux = {2'h0, flt_hi_reg};
    else if (addr == `CST_ADDR_FLT_LO)
      rd_mux = flt_reg[7:0];
    else if (addr == `CST_ADDR_SOC_A)
      rd_mux = soc_a_reg;
    else if (addr == `CST_ADDR_SOC_B)
      rd_mux = soc_b_reg;
    else if (addr == `CST_ADDR_RATE)
      rd_mux = {4'h0, rate_reg};
    else if (addr == `CST_ADDR_TUNE)
      rd_mux = {6'h00, tune_reg};
    else if (addr == `CST_ADDR_COARSE)
      rd_mux = {5'h00, coarse_reg};
    else if (addr == `CST_ADDR_FINE)
      rd_mux = {2'h0, fine_reg};
    else if (addr == `CST_ADDR_RCCAP)
      rd_mux = rccap_reg;
    else if (addr == `CST_ADDR_RBEN)
      rd_mux = {4'h0, rben_reg, 3'h0};
    else if (addr == `CST_ADDR_FLOAT)
      rd_mux = {4'h0, float_reg, 3'h0};
    else if (addr == `CST_ADDR_REV)
      rd_mux = REVISION_ID;
  end

  // trigger bits: set by a written one, cleared on done, set wins
  always @*
  begin
    tune_next = tune_reg;
    if (tune_done[1])
      tune_next[1] = 1'b0;
    if (tune_done[0])
      tune_next[0] = 1'b0;
    if (tune_start[1])
      tune_next[1] = 1'b1;
    if (tune_start[0])
      tune_next[0] = 1'b1;
  end

  // register writes; bits outside the documented fields are dropped
  always @(posedge MCLK_IN)
  begin
    if (bank_rst)
    begin
      fbd_hi_reg <= `CST_RST_FBD_HI;
      fbd_reg    <= {`CST_RST_FBD_HI, `CST_RST_FBD_LO};
      pump_reg   <= `CST_RST_PUMP;
      flt_hi_reg <= `CST_RST_FLT_HI;
      flt_reg    <= {`CST_RST_FLT_HI, `CST_RST_FLT_LO};
      soc_a_reg  <= `CST_RST_SOC_A;
      soc_b_reg  <= `CST_RST_SOC_B;
      rate_reg   <= `CST_RST_RATE;
      tune_reg   <= 2'h0;
      coarse_reg <= 3'h0;
      fine_reg   <= 6'h00;
      rccap_reg  <= 8'h00;
      rben_reg   <= 1'b0;
      float_reg  <= 1'b0;
    end
    else if (CE_IN)
    begin
      tune_reg <= tune_next;
      if (wr_stb)
      begin
        // high bytes are staged until their low byte lands
        if (addr == `CST_ADDR_FBD_HI)
          fbd_hi_reg <= wdata[4:0];
        else if (addr == `CST_ADDR_FBD_LO)
          fbd_reg <= {fbd_hi_reg, wdata};
        else if (addr == `CST_ADDR_PUMP)
          pump_reg <= wdata[6:0];
        else if (addr == `CST_ADDR_FLT_HI)
          flt_hi_reg <= wdata[5:0];
        else if (addr == `CST_ADDR_FLT_LO)
          flt_reg <= {flt_hi_reg, wdata};
        else if (addr == `CST_ADDR_SOC_A)
          soc_a_reg <= wdata;
        else if (addr == `CST_ADDR_SOC_B)
          soc_b_reg <= wdata;
        else if (addr == `CST_ADDR_RATE)
          rate_reg <= wdata[3:0];
        else if (addr == `CST_ADDR_COARSE)
          coarse_reg <= wdata[2:0];
        else if (addr == `CST_ADDR_FINE)
          fine_reg <= wdata[5:0];
        else if (addr == `CST_ADDR_RCCAP)
          rccap_reg <= wdata;
        else if (addr == `CST_ADDR_RBEN)
          rben_reg <= wdata[`CST_RBEN_BIT];
        else if (addr == `CST_ADDR_FLOAT)
          float_reg <= wdata[`CST_FLOAT_BIT];
      end
    end
  end

  // soft reset request, cleared only by the pin reset or by itself
  always @(posedge MCLK_IN)
  begin
    if (RST_IN)
      soft_rst_reg <= 1'b0;
    else if (CE_IN)
      soft_rst_reg <= wr_stb & (addr == `CST_ADDR_REV) &
                      (wdata == `CST_SOFT_RST_CODE);
  end

  // output clock tick: one high cycle every rate_reg clocks, zero acts as one
  always @(posedge MCLK_IN)
  begin
    if (bank_rst)
    begin
      div_cnt_reg             <= 4'h0;
      SERIAL_OUTPUT_CLOCK_OUT <= 1'b0;
    end
    else if (CE_IN)
    begin
      if (div_cnt_reg == 4'h0)
      begin
        SERIAL_OUTPUT_CLOCK_OUT <= 1'b1;
        div_cnt_reg <= (rate_reg == 4'h0) ? 4'h0 : rate_reg - 4'h1;
      end
      else
      begin
        SERIAL_OUTPUT_CLOCK_OUT <= 1'b0;
        div_cnt_reg <= div_cnt_reg - 4'h1;
      end
    end
  end

  // registered field decode; one cycle behind the storage
  always @(posedge MCLK_IN)
  begin
    if (bank_rst)
    begin
      CLOCK_FEEDBACK_DIVISOR_OUT <= {`CST_RST_FBD_HI, `CST_RST_FBD_LO};
      CLOCK_FAST_LOCK_ENABLE_OUT <= 1'b0;
      CLOCK_PUMP_POLARITY_OUT    <= 1'b0;
      CLOCK_PUMP_STEPS_OUT       <= 4'h1;
      CLOCK_PUMP_UP_OUT          <= 1'b1;
      CLOCK_PUMP_DOWN_OUT        <= 1'b1;
      CLOCK_PUMP_NORMAL_OUT      <= 1'b1;
      CLOCK_FAST_LOCK_TIME_OUT   <= {`CST_RST_FLT_HI, `CST_RST_FLT_LO};
      SERIAL_OUT_CONTROL_A_OUT   <= `CST_RST_SOC_A;
      SERIAL_OUT_CONTROL_B_OUT   <= `CST_RST_SOC_B;
      TANK_TUNING_BUSY_OUT       <= 1'b0;
      RC_TUNING_BUSY_OUT         <= 1'b0;
      TANK_COARSE_CAP_OUT        <= 3'h0;
      TANK_FINE_CAP_OUT          <= 6'h00;
      RC_RESONATOR_CAP_OUT       <= 8'h00;
      READBACK_ENABLE_OUT        <= 1'b0;
      FOUR_WIRE_MODE_OUT         <= 1'b0;
    end
    else if (CE_IN)
    begin
      CLOCK_FEEDBACK_DIVISOR_OUT <= fbd_reg;
      CLOCK_FAST_LOCK_ENABLE_OUT <= pump_reg[`CST_PUMP_FAST_BIT];
      CLOCK_PUMP_POLARITY_OUT    <= pump_reg[`CST_PUMP_POL_BIT];
      // steps of 0.625 mA, so field 0 still gives one step
      CLOCK_PUMP_STEPS_OUT <= {1'b0, pump_reg[`CST_PUMP_CUR_HI:`CST_PUMP_CUR_LO]} + 4'h1;
      // normal mode enables both directions under loop control
      case (pump_reg[`CST_PUMP_MODE_HI:`CST_PUMP_MODE_LO])
        `CST_MODE_OFF:
        begin
          CLOCK_PUMP_UP_OUT     <= 1'b0;
          CLOCK_PUMP_DOWN_OUT   <= 1'b0;
          CLOCK_PUMP_NORMAL_OUT <= 1'b0;
        end
        `CST_MODE_UP:
        begin
          CLOCK_PUMP_UP_OUT     <= 1'b1;
          CLOCK_PUMP_DOWN_OUT   <= 1'b0;
          CLOCK_PUMP_NORMAL_OUT <= 1'b0;
        end
        `CST_MODE_DOWN:
        begin
          CLOCK_PUMP_UP_OUT     <= 1'b0;
          CLOCK_PUMP_DOWN_OUT   <= 1'b1;
          CLOCK_PUMP_NORMAL_OUT <= 1'b0;
        end
        default:
        begin
          CLOCK_PUMP_UP_OUT     <= 1'b1;
          CLOCK_PUMP_DOWN_OUT   <= 1'b1;
          CLOCK_PUMP_NORMAL_OUT <= 1'b1;
        end
      endcase
      CLOCK_FAST_LOCK_TIME_OUT <= flt_reg;
      SERIAL_OUT_CONTROL_A_OUT <= soc_a_reg;
      SERIAL_OUT_CONTROL_B_OUT <= soc_b_reg;
      TANK_TUNING_BUSY_OUT     <= tune_busy[1];
      RC_TUNING_BUSY_OUT       <= tune_busy[0];
      TANK_COARSE_CAP_OUT      <= coarse_reg;
      TANK_FINE_CAP_OUT        <= fine_reg;
      RC_RESONATOR_CAP_OUT     <= rccap_reg;
      READBACK_ENABLE_OUT      <= rben_reg;
      FOUR_WIRE_MODE_OUT       <= four_wire;
    end
  end

  // secondary output copies read data in four-wire mode, low otherwise;
  // it drives low after reset, so a shared line must set the float bit first
  always @(posedge MCLK_IN)
  begin
    if (bank_rst)
    begin
      SECONDARY_SERIAL_OUTPUT_OUT      <= 1'b0;
      SECONDARY_SERIAL_OUTPUT_OE_N_OUT <= 1'b0;
    end
    else if (CE_IN)
    begin
      SECONDARY_SERIAL_OUTPUT_OUT      <= four_wire & sdo;
      SECONDARY_SERIAL_OUTPUT_OE_N_OUT <= float_reg;
    end
  end

endmodule // cst_regs_top

/* sim/cst_regs_top_properties.sv */
// port assertions for the register bank
`timescale 1ns/100ps
module cst_regs_props
#(
  parameter [15:0] TUNE_CYCLES = 16'd50
)
(
  // clock, reset, port pins
  input wire        MCLK_IN,
  input wire        RST_IN,
  input wire        SPORT_SEL_N_IN,
  input wire        SPORT_DATA_OE_N_OUT,
  input wire        SECONDARY_SERIAL_OUTPUT_OUT,
  // settings and status
  input wire [12:0] CLOCK_FEEDBACK_DIVISOR_OUT,
  input wire [3:0]  CLOCK_PUMP_STEPS_OUT,
  input wire        CLOCK_PUMP_UP_OUT,
  input wire        CLOCK_PUMP_DOWN_OUT,
  input wire        CLOCK_PUMP_NORMAL_OUT,
  input wire [13:0] CLOCK_FAST_LOCK_TIME_OUT,
  input wire [7:0]  SERIAL_OUT_CONTROL_A_OUT,
  input wire [7:0]  SERIAL_OUT_CONTROL_B_OUT,
  input wire        TANK_TUNING_BUSY_OUT,
  input wire        RC_TUNING_BUSY_OUT,
  input wire        READBACK_ENABLE_OUT,
  input wire        FOUR_WIRE_MODE_OUT
);
  reg  [15:0] lc_cnt_reg;
  reg  [15:0] rc_cnt_reg;
  // busy run lengths, counted here since repetition counts must be literal
  always @(posedge MCLK_IN)
  begin
    lc_cnt_reg <= (RST_IN || !TANK_TUNING_BUSY_OUT) ? 16'h0 : lc_cnt_reg + 16'h1;
    rc_cnt_reg <= (RST_IN || !RC_TUNING_BUSY_OUT) ? 16'h0 : rc_cnt_reg + 16'h1;
  end
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);
  // assertions
  a_reset_defaults: assert property ($fell(RST_IN) |->
    CLOCK_FEEDBACK_DIVISOR_OUT == 13'h3c && CLOCK_FAST_LOCK_TIME_OUT == 14'h4 &&
    SERIAL_OUT_CONTROL_A_OUT == 8'h12 && SERIAL_OUT_CONTROL_B_OUT == 8'h07) else $error("bad reset values");
  a_pump_steps: assert property (CLOCK_PUMP_STEPS_OUT != 4'h0 && CLOCK_PUMP_STEPS_OUT <= 4'h8)
    else $error("pump current out of range");
  a_mode_decode: assert property (CLOCK_PUMP_NORMAL_OUT == (CLOCK_PUMP_UP_OUT && CLOCK_PUMP_DOWN_OUT))
    else $error("illegal pump mode decode");
  a_tank_length: assert property ($fell(TANK_TUNING_BUSY_OUT) |-> lc_cnt_reg == TUNE_CYCLES)
    else $error("tank tuning length wrong");
  a_rc_bound: assert property (RC_TUNING_BUSY_OUT |-> rc_cnt_reg < TUNE_CYCLES)
    else $error("rc tuning runs too long");
  a_four_wire: assert property (FOUR_WIRE_MODE_OUT |-> SERIAL_OUT_CONTROL_B_OUT[7] && !READBACK_ENABLE_OUT)
    else $error("four-wire mode without its cause");
  a_sec_quiet: assert property (!FOUR_WIRE_MODE_OUT [*2] |-> !SECONDARY_SERIAL_OUTPUT_OUT)
    else $error("secondary output active in three-wire");
  a_read_refused: assert property ((!READBACK_ENABLE_OUT && !FOUR_WIRE_MODE_OUT) [*3] |-> SPORT_DATA_OE_N_OUT)
    else $error("data pin driven with read-back off");
  a_oe_release: assert property (SPORT_SEL_N_IN [*2] |=> SPORT_DATA_OE_N_OUT)
    else $error("data pin held after deselect");
  // main scenarios
  c_tank: cover property ($fell(TANK_TUNING_BUSY_OUT));
  c_four: cover property ($rose(FOUR_WIRE_MODE_OUT));
  c_read: cover property ($fell(SPORT_DATA_OE_N_OUT));
endmodule // cst_regs_props

bind cst_regs_top cst_regs_props #(.TUNE_CYCLES(TUNE_CYCLES)) i_cst_regs_props (
  .MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .SPORT_SEL_N_IN(SPORT_SEL_N_IN),
  .SPORT_DATA_OE_N_OUT(SPORT_DATA_OE_N_OUT), .SECONDARY_SERIAL_OUTPUT_OUT(SECONDARY_SERIAL_OUTPUT_OUT),
  .CLOCK_FEEDBACK_DIVISOR_OUT(CLOCK_FEEDBACK_DIVISOR_OUT), .CLOCK_PUMP_STEPS_OUT(CLOCK_PUMP_STEPS_OUT),
  .CLOCK_PUMP_UP_OUT(CLOCK_PUMP_UP_OUT), .CLOCK_PUMP_DOWN_OUT(CLOCK_PUMP_DOWN_OUT),
  .CLOCK_PUMP_NORMAL_OUT(CLOCK_PUMP_NORMAL_OUT), .CLOCK_FAST_LOCK_TIME_OUT(CLOCK_FAST_LOCK_TIME_OUT),
  .SERIAL_OUT_CONTROL_A_OUT(SERIAL_OUT_CONTROL_A_OUT), .SERIAL_OUT_CONTROL_B_OUT(SERIAL_OUT_CONTROL_B_OUT),
  .TANK_TUNING_BUSY_OUT(TANK_TUNING_BUSY_OUT), .RC_TUNING_BUSY_OUT(RC_TUNING_BUSY_OUT),
  .READBACK_ENABLE_OUT(READBACK_ENABLE_OUT), .FOUR_WIRE_MODE_OUT(FOUR_WIRE_MODE_OUT));

/* sim/cst_host_model.sv */
// host controller model driving the configuration port
`timescale 1ns/100ps
module cst_host_model
(
  // system clock and device data side
  input  wire clk_in,
  input  wire dout_in,
  input  wire oe_n_in,
  // port pins
  output reg  sck_out,
  output reg  sel_n_out,
  output wire sdi_out
);
  reg drv_reg;
  reg seen_reg;
  // device drive wins; a released line toggles so stale bits never look valid
  assign sdi_out = oe_n_in ? drv_reg : dout_in;
  initial
  begin
    sck_out = 1'b0;
    sel_n_out = 1'b1;
    drv_reg = 1'b0;
    seen_reg = 1'b0;
  end
  // one port clock: two cycles low with data set, sample, two cycles high
  task bitx(input logic d, output logic s);
  begin
    drv_reg = d;
    repeat (2) @(negedge clk_in);
    s = sdi_out;
    seen_reg = seen_reg | ~oe_n_in;
    sck_out = 1'b1;
    repeat (2) @(negedge clk_in);
    sck_out = 1'b0;
  end
  endtask
  // whole frame: header msb first, then write bytes or one read byte
  task frame(input logic rd, input logic [5:0] a, input logic [7:0] d [$], output logic [7:0] q);
    logic [7:0] h;
    logic       s;
  begin
    h = {rd, a, 1'b0};
    seen_reg = 1'b0;
    sel_n_out = 1'b0;
    for (int i = 7; i >= 0; i--) bitx(h[i], s);
    foreach (d[k])
      for (int i = 7; i >= 0; i--) bitx(d[k][i], s);
    if (rd)
      for (int i = 7; i >= 0; i--)
      begin
        bitx(~drv_reg, s);
        q[i] = s;
      end
    repeat (2) @(negedge clk_in);
    sel_n_out = 1'b1; // deselect between reads
    repeat (2) @(negedge clk_in);
  end
  endtask
endmodule // cst_host_model

/* sim/tb_cst_regs_top.sv */
// self-checking bench for the register bank
`timescale 1ns/100ps
module tb_cst_regs_top;
  localparam [7:0] REV = 8'hc3; // arbitrary value
  reg         clk;
  reg         rst;
  wire        sck, seln, sdi, dout, oen, sec, soe, fast, pol, up, dn, nrm, socl, tank, rcb, rdb, fw;
  wire [12:0] fbd;
  wire [3:0]  stp;
  wire [13:0] flt;
  wire [7:0]  sa, sb, rcp;
  wire [2:0]  cc;
  wire [5:0]  fc;
  int         mem [64];
  int         fbd_m, flt_m, err_total, compares, k;
  logic [7:0] q;
  logic [7:0] wq [$];
  logic [7:0] nq [$];
  int         ad [] = '{'h12, 'h13, 'h14, 'h15, 'h16, 'h17, 'h18, 'h19, 'h1a, 'h1c, 'h1d, 'h1f, 'h37, 'h3a, 'h3f};
  // design and host
  cst_regs_top #(.REVISION_ID(REV), .TUNE_CYCLES(16'd4)) i_cst_regs_top (
    .MCLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1), .SPORT_CLK_IN(sck), .SPORT_SEL_N_IN(seln),
    .SPORT_DATA_IN(sdi), .SPORT_DATA_OUT(dout), .SPORT_DATA_OE_N_OUT(oen),
    .SECONDARY_SERIAL_OUTPUT_OUT(sec), .SECONDARY_SERIAL_OUTPUT_OE_N_OUT(soe),
    .CLOCK_FEEDBACK_DIVISOR_OUT(fbd), .CLOCK_FAST_LOCK_ENABLE_OUT(fast), .CLOCK_PUMP_POLARITY_OUT(pol),
    .CLOCK_PUMP_STEPS_OUT(stp), .CLOCK_PUMP_UP_OUT(up), .CLOCK_PUMP_DOWN_OUT(dn), .CLOCK_PUMP_NORMAL_OUT(nrm),
    .CLOCK_FAST_LOCK_TIME_OUT(flt), .SERIAL_OUT_CONTROL_A_OUT(sa), .SERIAL_OUT_CONTROL_B_OUT(sb),
    .SERIAL_OUTPUT_CLOCK_OUT(socl), .TANK_TUNING_BUSY_OUT(tank), .RC_TUNING_BUSY_OUT(rcb),
    .TANK_COARSE_CAP_OUT(cc), .TANK_FINE_CAP_OUT(fc), .RC_RESONATOR_CAP_OUT(rcp),
    .READBACK_ENABLE_OUT(rdb), .FOUR_WIRE_MODE_OUT(fw));
  cst_host_model i_host (.clk_in(clk), .dout_in(fw ? sec : dout), .oe_n_in(oen), .sck_out(sck), .sel_n_out(seln), .sdi_out(sdi));
  // 25 MHz clock
  initial clk = 1'b0;
  always #20 clk = ~clk;
  // value comparison
  task chk(input logic [15:0] got, input logic [15:0] exp);
  begin
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // reference model: stored bits and reset values per address
  function int msk(int a);
    case (a)
      'h12: return 'h1f;
      'h14: return 'h7f;
      'h15, 'h1e: return 'h3f;
      'h1a: return 'hf;
      'h1d: return 7;
      'h3a, 'h3b: return 8;
      'h13, 'h16, 'h18, 'h19, 'h1f: return 'hff;
      default: return 0;
    endcase
  endfunction
  function int rv(int a);
    case (a)
      'h13: return 'h3c;
      'h14: return 3;
      'h16: return 4;
      'h18: return 'h12;
      'h19: return 7;
      'h1a: return 1;
      default: return 0;
    endcase
  endfunction
  task mreset;
  begin
    foreach (mem[i]) mem[i] = rv(i);
    fbd_m = 'h3c;
    flt_m = 4;
  end
  endtask
  // a byte lands in the model; wide values apply on their low byte only
  task mw(input int a, input int d);
  begin
    if (a == 'h3f && d == 'h99) mreset;
    else mem[a] = d & msk(a);
    if (a == 'h13) fbd_m = mem['h12] * 256 + mem['h13];
    if (a == 'h16) flt_m = mem['h15] * 256 + mem['h16];
  end
  endtask
  task wr(input int a, input logic [7:0] d [$]);
  begin
    i_host.frame(1'b0, a[5:0], d, q);
    foreach (d[i]) mw(a + i, d[i]);
    repeat (4) @(negedge clk);
  end
  endtask
  task rd(input int a, input int e);
  begin
    i_host.frame(1'b1, a[5:0], nq, q);
    chk(q, e[7:0]);
  end
  endtask
  // every setting output except the serial output clock against the model
  task outs;
    int p;
  begin
    p = mem['h14];
    chk(fbd, fbd_m);
    chk(flt, flt_m);
    chk({fast, pol, stp}, p[6:5] * 16 + p[4:2] + 1);
    chk({up, dn, nrm}, p[1:0] == 3 ? 7 : p[1:0] == 1 ? 4 : p[1:0] == 2 ? 2 : 0);
    chk({sa, sb}, mem['h18] * 256 + mem['h19]);
    chk({cc, fc}, mem['h1d] * 64 + mem['h1e]);
    chk(rcp, mem['h1f]);
    chk({rdb, fw, soe}, {mem['h3a][3], mem['h19][7] && mem['h3a] == 0, mem['h3b][3]});
  end
  endtask
  task summarize;
  begin
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  // hang guard, well beyond the expected run
  initial
  begin
    #(40 * 40000);
    err_total++;
    summarize;
  end
  // main sequence
  initial
  begin
    void'($urandom(32'hdc2fc588));
    rst = 1'b1;
    mreset;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    outs;
    i_host.frame(1'b1, 6'h13, nq, q);
    chk(i_host.seen_reg, 0);
    $display("test reset and refused read done");
    wr('h3a, {8'h08});
    for (k = 0; k < 14; k++) wq.push_back($urandom);
    wq[1] = wq[1] | 8'h04;
    wr('h12, wq);
    outs;
    foreach (ad[i]) rd(ad[i], ad[i] == 'h3f ? REV : mem[ad[i]]);
    wr('h12, {8'h0a});
    outs;
    rd('h12, 'h0a);
    wr('h13, {8'h55});
    wr('h15, {8'h2b});
    outs;
    wr('h16, {8'h07});
    outs;
    $display("test burst, readback and staging done");
    for (k = 0; k < 4; k++)
    begin
      wr('h14, {8'($urandom) & 8'h7c | 8'(k)});
      outs;
    end
    foreach (ad[i])
      if (i > 0 && i < 6)
      begin
        wr('h1a, {8'(i * 2 - 1)});
        repeat (16) @(negedge clk);
        k = 0;
        repeat (315) @(negedge clk) k = k + socl;
        chk(k, 315 / (i * 2 - 1));
      end
    $display("test pump modes and rate done");
    for (int b = 0; b < 2; b++)
      fork
        wr('h1c, {8'(1 << b)});
        begin
          k = 0;
          while ({tank, rcb} === 2'b00 && k < 300)
          begin
            @(negedge clk);
            k++;
          end
          chk({tank, rcb}, 1 << b);
        end
      join
    rd('h1c, 0);
    $display("test tuning done");
    wr('h19, {8'h87});
    wr('h3a, {8'h00});
    outs;
    rd('h19, 'h87);
    wr('h3b, {8'h08});
    outs;
    wr('h3f, {8'h99});
    outs;
    $display("test four-wire, float and soft reset done");
    summarize;
  end
endmodule // tb_cst_regs_top
